// ==== hdl/flash_block_erase_protect.sv ====
`timescale 1ns/1ps
module flash_block_erase_protect
    import flash_prot_pkg::*;
#(
    parameter int ERASE_STEP_WORDS = 1
) (
    input  wire logic                              core_clk,
    input  wire logic                              rst_n,
    input  wire logic                              req_valid,
    input  wire logic [1:0]                        req_op,
    input  wire logic                              req_debug,
    input  wire logic [flash_prot_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [flash_prot_pkg::DATA_W-1:0] req_wdata,
    input  wire logic [flash_prot_pkg::REGIONS-1:0] ro_mask,
    input  wire logic [flash_prot_pkg::REGIONS-1:0] xo_mask,
    input  wire logic                              viol_clear,
    output logic                                   rsp_valid,
    output logic      [flash_prot_pkg::DATA_W-1:0] rsp_rdata,
    output logic                                   rsp_denied,
    output logic                                   erase_busy,
    output logic                                   viol_flag
);
    import flash_prot_pkg::*;

    localparam logic [BLOCK_OFF_W-1:0] LAST_OFF = BLOCK_OFF_W'(BLOCK_WORDS - 1);

    // refuse settings the sweep and the decode cannot serve
    if (ERASE_STEP_WORDS != 1) begin : g_bad_step
        $error("erase sweep writes exactly one word per clock");
    end
    if (WORDS != (1 << ADDR_W)) begin : g_bad_words
        $error("word count does not match address width");
    end
    if (BLOCK_WORDS != (1 << BLOCK_OFF_W)) begin : g_bad_block
        $error("block size does not match block offset width");
    end
    if (BLOCKS != (1 << BLOCK_W)) begin : g_bad_blocks
        $error("block count does not match block index width");
    end
    if (REGIONS != (1 << REGION_W) || BLOCK_W != REGION_W + 1) begin : g_bad_regions
        $error("a region must be exactly two blocks");
    end

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_ERASE = 2'b10
    } erase_state_e;

    // flash array
    logic [DATA_W-1:0]       mem [WORDS];

    // request decode
    logic                    is_ro;
    logic                    is_xo;
    logic                    deny;
    logic                    take;

    // erase sequencer
    erase_state_e            state_reg;
    erase_state_e            state_next;
    logic [BLOCK_W-1:0]      blk_reg;
    logic [BLOCK_W-1:0]      blk_next;
    logic [BLOCK_OFF_W-1:0]  off_reg;
    logic [BLOCK_OFF_W-1:0]  off_next;
    logic                    busy_reg;
    logic                    busy_next;
    logic                    sweep_done;

    // response
    logic                    rsp_valid_reg;
    logic                    rsp_valid_next;
    logic [DATA_W-1:0]       rsp_rdata_reg;
    logic [DATA_W-1:0]       rsp_rdata_next;
    logic                    rsp_denied_reg;
    logic                    rsp_denied_next;

    // violation flag
    logic                    viol_reg;
    logic                    viol_next;

    // array write port
    logic                    wr_en;
    logic [ADDR_W-1:0]       wr_addr;
    logic [DATA_W-1:0]       wr_data;

    function automatic logic [REGION_W-1:0] region_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1 -: REGION_W];
    endfunction

    function automatic logic [BLOCK_W-1:0] block_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1 -: BLOCK_W];
    endfunction

    function automatic logic refused(
        input logic [1:0] op,
        input logic       dbg,
        input logic       ro,
        input logic       xo
    );
        logic r;
        r = 1'b0;
        case (op)
            OP_PROG, OP_ERASE: r = ro | xo;
            OP_READ:           r = xo;
            OP_FETCH:          r = xo & dbg; // a debugger fetch is refused only in an execute-only region
            default:           r = 1'b0;
        endcase
        return r;
    endfunction

    always_comb begin
        is_ro = ro_mask[region_of(req_addr)];
        is_xo = xo_mask[region_of(req_addr)];
        deny  = refused(req_op, req_debug, is_ro, is_xo);
        take  = req_valid & (state_reg == ST_IDLE);
    end

    always_comb begin
        state_next = state_reg;
        blk_next   = blk_reg;
        off_next   = off_reg;
        sweep_done = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (take && !deny && req_op == OP_ERASE) begin
                    blk_next   = block_of(req_addr);
                    off_next   = '0;
                    state_next = ST_ERASE;
                end
            end
            ST_ERASE: begin
                off_next = off_reg + BLOCK_OFF_W'(1);
                if (off_reg == LAST_OFF) begin
                    state_next = ST_IDLE;
                    sweep_done = 1'b1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        busy_next = (state_next == ST_ERASE);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            blk_reg   <= '0;
            off_reg   <= '0;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            blk_reg   <= blk_next;
            off_reg   <= off_next;
            busy_reg  <= busy_next;
        end
    end

    always_comb begin
        wr_en   = 1'b0;
        wr_addr = '0;
        wr_data = ERASED_WORD;
        if (state_reg == ST_ERASE) begin
            wr_en   = 1'b1;
            wr_addr = {blk_reg, off_reg};
            wr_data = ERASED_WORD;
        end else if (take && !deny && req_op == OP_PROG) begin
            wr_en   = 1'b1; // refused requests never write
            wr_addr = req_addr;
            wr_data = mem[req_addr] & req_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_comb begin
        rsp_valid_next  = sweep_done;
        rsp_rdata_next  = '0;
        rsp_denied_next = 1'b0;
        if (take) begin
            rsp_valid_next = 1'b1;
            if (deny) begin
                rsp_denied_next = 1'b1;
            end else if (req_op == OP_READ || req_op == OP_FETCH) begin
                rsp_rdata_next = mem[req_addr];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_reg  <= 1'b0;
            rsp_rdata_reg  <= '0;
            rsp_denied_reg <= 1'b0;
        end else begin
            rsp_valid_reg  <= rsp_valid_next;
            rsp_rdata_reg  <= rsp_rdata_next;
            rsp_denied_reg <= rsp_denied_next;
        end
    end

    always_comb begin
        viol_next = viol_reg & ~viol_clear;
        if (take && deny) begin
            viol_next = 1'b1; // a new violation beats a clear
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            viol_reg <= 1'b0;
        end else begin
            viol_reg <= viol_next;
        end
    end

    always_comb begin
        rsp_valid  = rsp_valid_reg;
        rsp_rdata  = rsp_rdata_reg;
        rsp_denied = rsp_denied_reg;
        erase_busy = busy_reg;
        viol_flag  = viol_reg;
    end
endmodule // flash_block_erase_protect

// ==== hdl/flash_prot_pkg.sv ====
package flash_prot_pkg;
    // array geometry
    localparam int FLASH_BYTES     = 32768;
    localparam int BLOCK_BYTES     = 1024;
    localparam int WORD_BYTES      = 4;
    localparam int DATA_W          = 32;
    localparam int WORDS           = FLASH_BYTES / WORD_BYTES;
    localparam int ADDR_W          = 13;
    localparam int BLOCK_WORDS     = BLOCK_BYTES / WORD_BYTES;
    localparam int BLOCK_OFF_W     = 8;
    localparam int BLOCKS          = FLASH_BYTES / BLOCK_BYTES;
    localparam int BLOCK_W         = 5;
    localparam int REGIONS         = BLOCKS / 2;
    localparam int REGION_W        = 4;
    // request kinds
    localparam logic [1:0] OP_READ  = 2'h0;
    localparam logic [1:0] OP_FETCH = 2'h1;
    localparam logic [1:0] OP_PROG  = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [DATA_W-1:0] ERASED_WORD = 32'hffffffff;
endpackage

// ==== testbench/flash_prot_checker.sv ====
`timescale 1ns/1ps
module flash_prot_checker import flash_prot_pkg::*; (
    input wire logic core_clk, rst_n, req_valid, req_debug,
    input wire logic rsp_valid, rsp_denied, erase_busy, viol_flag,
    input wire logic [1:0] req_op,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] rsp_rdata,
    input wire logic [REGIONS-1:0] ro_mask, xo_mask
);
    wire logic [3:0] rg = req_addr[12:9];
    wire logic tk = req_valid && !erase_busy;
    wire logic bad = req_op[1] ? ro_mask[rg] | xo_mask[rg]
                               : (req_op == OP_READ || req_debug) && xo_mask[rg];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_answer_next: assert property (tk |=> rsp_valid) else $error("late");
    chk_busy_ignore: assert property (erase_busy && $past(erase_busy) |-> !rsp_valid)
        else $error("busy answer");
    chk_guard_hold: assert property (tk && bad |=> !erase_busy) else $error("sweep");
    chk_sweep_start: assert property (tk && &req_op && !bad |=> erase_busy)
        else $error("no sweep");
    chk_sweep_span: assert property ($rose(erase_busy) |-> ##256 rsp_valid && !erase_busy)
        else $error("sweep span");
    chk_guard_deny: assert property (tk && bad |=> rsp_denied) else $error("kept");
    chk_open_pass: assert property (tk && !bad |=> !rsp_denied) else $error("denied");
    chk_deny_zero: assert property (rsp_denied |-> rsp_valid && rsp_rdata == '0)
        else $error("data");
    chk_flag_raise: assert property (rsp_denied |-> viol_flag) else $error("no flag");
endmodule // flash_prot_checker
bind flash_block_erase_protect flash_prot_checker u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req_debug(req_debug),
    .rsp_valid(rsp_valid), .rsp_denied(rsp_denied), .erase_busy(erase_busy),
    .viol_flag(viol_flag), .req_op(req_op), .req_addr(req_addr), .rsp_rdata(rsp_rdata),
    .ro_mask(ro_mask), .xo_mask(xo_mask)
);

// ==== testbench/flash_bus_master.sv ====
`timescale 1ns/1ps
module flash_bus_master import flash_prot_pkg::*; (
    input  wire logic core_clk,
    output logic      req_valid, req_debug,
    output logic      [1:0] req_op,
    output logic      [flash_prot_pkg::ADDR_W-1:0] req_addr,
    output logic      [flash_prot_pkg::DATA_W-1:0] req_wdata
);
    initial {req_valid, req_debug, req_op, req_addr, req_wdata} = '0;
    task automatic issue(input logic [1:0] o, input logic d, input logic [12:0] a,
                         input logic [31:0] w);
        repeat ($urandom % 3) @(posedge core_clk);
        @(posedge core_clk);
        {req_valid, req_op, req_debug, req_addr, req_wdata} <= {1'b1, o, d, a, w};
        @(posedge core_clk);
        {req_valid, req_addr, req_wdata} <= {1'b0, ~a, ~w};
    endtask
endmodule // flash_bus_master

// ==== testbench/flash_block_erase_protect_tb_top.sv ====
`timescale 1ns/1ps
module flash_block_erase_protect_tb_top;
    import flash_prot_pkg::*;
    logic core_clk = 0, rst_n = 0, viol_clear = 0, req_valid, req_debug;
    logic rsp_valid, rsp_denied, erase_busy, viol_flag;
    logic [1:0] req_op;
    logic [12:0] req_addr;
    logic [31:0] req_wdata, rsp_rdata;
    logic [15:0] ro_mask = 0, xo_mask = 0;
    int n_errors, n_checks, n, v, bad;
    int unsigned mem [8192];
    always #10 core_clk = ~core_clk;
    flash_bus_master u_master (
        .core_clk(core_clk), .req_valid(req_valid), .req_debug(req_debug),
        .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata)
    );
    flash_block_erase_protect DUT (
        .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
        .req_debug(req_debug), .req_addr(req_addr), .req_wdata(req_wdata),
        .ro_mask(ro_mask), .xo_mask(xo_mask), .viol_clear(viol_clear),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_denied(rsp_denied),
        .erase_busy(erase_busy), .viol_flag(viol_flag)
    );
    task chk(input logic [31:0] s, e);
        n_checks++;
        n_errors += int'(s !== e);
        if (s !== e) $display("BAD %0t %h %h", $time, s, e);
    endtask
    task summarize;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task op(input logic [1:0] o, input logic [12:0] a);
        logic [31:0] w;
        time t;
        w = $urandom;
        bad = o[1] ? ro_mask[a[12:9]] | xo_mask[a[12:9]] : (o == 0 || w[0]) && xo_mask[a[12:9]];
        u_master.issue(o, w[0], a, w);
        n = 1;
        #1;
        while (!rsp_valid && n < 300) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk(n, 1);
        chk(rsp_denied, bad);
        v |= bad;
        chk(viol_flag, v);
        chk(rsp_rdata, bad || o[1] ? 0 : mem[a]);
        chk(erase_busy, o == 3 && !bad);
        if (!bad && o == 2) mem[a] &= w;
        if (!bad && o == 3) begin
            t = $time;
            u_master.issue(2'h2, 1'b0, a, 32'h0);
            #1;
            while (!rsp_valid && $time - t < 6000) begin
                @(posedge core_clk);
                #1;
            end
            chk(32'(($time - t) / 20), BLOCK_WORDS);
            chk(erase_busy, 0);
            for (int i = 0; i < BLOCK_WORDS; i++) mem[{a[12:8], 8'h0} + i] = '1;
        end
    endtask
    initial begin
        void'($urandom(68242));
        repeat (10) @(posedge core_clk);
        rst_n <= 1;
        for (int b = 0; b < BLOCKS; b++) op(2'h3, 13'(b * BLOCK_WORDS));
        repeat (150) begin
            @(posedge core_clk);
            {ro_mask, xo_mask, viol_clear} <= {16'($urandom), 16'($urandom), 1'($urandom)};
            @(posedge core_clk);
            if (viol_clear) v = 0;
            viol_clear <= 0;
            op(2'($urandom), 13'($urandom));
        end
        summarize;
    end
    initial begin
        #1000000 n_errors++;
        summarize;
    end
endmodule // flash_block_erase_protect_tb_top
